/* File: pkg/usf_pkg.sv */
// Constants, register map and event carriers for the serial status-flag block.
// Assumes one bus clock and a simple strobe register port in front of it.
// Functional notes
// - Transmit buffer empty sets at reset and on buffer-to-shifter transfer.
// - Transmit buffer empty clears on armed status read then data write.
// - Transmit complete sets at reset and when buffer empty and line idle.
// - Armed transmit complete clears on data write, enable rise, or break write.
// - Receive full sets on character transfer; clears on armed read then data read.
// - Idle flag sets after 10 or 11 high bit times following activity.
// - Idle select 0 starts the idle count right after the start bit.
// - Idle select 1 starts the idle count only after the stop bit.
// - Idle clears on armed read sequence; rearms only after new receive full.
// - Overrun sets when new character meets unread one; new character discarded.
// - Disagreeing samples in any bit set noise together with receive full.
// - Noise clears on status read then data read, armed or not.
// - Framing error sets with receive full when stop bit samples low.
// - Parity error sets with receive full when enabled parity mismatches.
// - Status register is read-only; flags clear only by read-then-access.
package usf_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DATA_PORT = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h5;

  // Status flag positions
  localparam int unsigned BIT_TX_EMPTY = 7;
  localparam int unsigned BIT_TX_DONE = 6;
  localparam int unsigned BIT_RX_FULL = 5;
  localparam int unsigned BIT_IDLE = 4;
  localparam int unsigned BIT_OVERRUN = 3;
  localparam int unsigned BIT_NOISE = 2;
  localparam int unsigned BIT_FRAME = 1;
  localparam int unsigned BIT_PARITY = 0;

  // Control and configuration field positions
  localparam int unsigned BIT_TX_ON = 3;
  localparam int unsigned BIT_QUEUE_BREAK = 0;
  localparam int unsigned BIT_IDLE_SEL = 2;
  localparam int unsigned BIT_LONG_CHAR = 4;

  // Reset values and unmapped read data
  localparam logic [DATA_W-1:0] RST_STATUS = 8'hC0;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

  // Character lengths in bit times
  localparam logic [3:0] CHAR_BITS_SHORT = 4'hA;
  localparam logic [3:0] CHAR_BITS_LONG = 4'hB;

  // Receiver character event from the shifter
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic noise;
    logic frame_err;
    logic parity_err;
  } usf_rx_char_t;

  // Transmitter state from the shifter
  typedef struct packed {
    logic load;
    logic busy;
  } usf_tx_state_t;

  // Receiver line-timing events
  typedef struct packed {
    logic bit_tick;
    logic line_high;
    logic start_done;
    logic stop_done;
  } usf_rx_line_t;

endpackage : usf_pkg

/* File: design/usf_status_flags.sv */
// Status-flag logic of the serial interface: flags, clear sequences, idle count.
// Assumes shifter logic on the same clock delivers one-cycle events.
module usf_status_flags
  import usf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire usf_rx_char_t rx_char,
  input wire usf_tx_state_t tx_state,
  input wire usf_rx_line_t rx_line,
  output logic [DATA_W-1:0] tx_data,
  output logic tx_data_valid,
  output logic tx_on,
  output logic queue_break,
  output logic parity_on,
  output logic irq
);

  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] armed_q;
  logic [DATA_W-1:0] rx_data_q;
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] irq_stat_q;
  logic [DATA_W-1:0] irq_mask_q;
  logic [DATA_W-1:0] tx_data_q;
  logic tx_data_valid_q;
  logic [3:0] idle_cnt_q;
  logic idle_run_q;
  logic idle_allow_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] status_d;
  logic [DATA_W-1:0] set_v;
  logic [DATA_W-1:0] clr_v;
  logic [DATA_W-1:0] status_prev_q;

  // Decode helper shared by every write and by the status and data reads
  function automatic logic hit(input logic stb, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = stb && (a == ofs);
  endfunction : hit

  logic st_rd;
  logic dat_rd;
  logic dat_wr;
  logic ctl_wr;
  logic tx_rise;
  logic brk_wr;
  logic rx_take;
  logic [3:0] char_bits;
  logic idle_set;

  assign st_rd = hit(reg_rd, reg_addr, OFS_STATUS_ONE);
  assign dat_rd = hit(reg_rd, reg_addr, OFS_DATA_PORT);
  assign dat_wr = hit(reg_wr, reg_addr, OFS_DATA_PORT);
  assign ctl_wr = hit(reg_wr, reg_addr, OFS_CONTROL_TWO);
  // Enable rise queues a preamble; break write counts on any 1 written
  assign tx_rise = ctl_wr && reg_wdata[BIT_TX_ON] && !ctrl_q[BIT_TX_ON];
  assign brk_wr = ctl_wr && reg_wdata[BIT_QUEUE_BREAK];
  // Character dropped whole when previous one unread
  assign rx_take = rx_char.valid && !status_q[BIT_RX_FULL];
  assign char_bits = cfg_q[BIT_LONG_CHAR] ? CHAR_BITS_LONG : CHAR_BITS_SHORT;

  // Set terms from transmitter and receiver events
  always_comb begin
    set_v = '0;
    set_v[BIT_TX_EMPTY] = tx_state.load;
    // A data write, preamble or break being queued this cycle is activity, not idle
    set_v[BIT_TX_DONE] = status_q[BIT_TX_EMPTY] && !tx_state.busy && !tx_state.load &&
                         !(dat_wr || tx_rise || brk_wr);
    set_v[BIT_RX_FULL] = rx_take;
    set_v[BIT_IDLE] = idle_set;
    set_v[BIT_OVERRUN] = rx_char.valid && status_q[BIT_RX_FULL];
    set_v[BIT_NOISE] = rx_take && rx_char.noise;
    set_v[BIT_FRAME] = rx_take && rx_char.frame_err;
    set_v[BIT_PARITY] = rx_take && rx_char.parity_err && cfg_q[BIT_PARITY];
  end

  // Clear terms: only flags armed by an earlier status read clear
  always_comb begin
    clr_v = '0;
    clr_v[BIT_TX_EMPTY] = dat_wr && armed_q[BIT_TX_EMPTY];
    clr_v[BIT_TX_DONE] = (dat_wr || tx_rise || brk_wr) && armed_q[BIT_TX_DONE];
    clr_v[BIT_RX_FULL] = dat_rd && armed_q[BIT_RX_FULL];
    clr_v[BIT_IDLE] = dat_rd && armed_q[BIT_IDLE];
    clr_v[BIT_OVERRUN] = dat_rd && armed_q[BIT_OVERRUN];
    clr_v[BIT_NOISE] = dat_rd && armed_q[BIT_NOISE];
    clr_v[BIT_FRAME] = dat_rd && armed_q[BIT_FRAME];
    clr_v[BIT_PARITY] = dat_rd && armed_q[BIT_PARITY];
    // Set beats clear in the same cycle so no event is lost
    status_d = (status_q & ~clr_v) | set_v;
  end

  // Status flags; bus writes never reach this register
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // Arming: a status read records the flags it saw set
  always_ff @(posedge clk) begin
    if (rst) begin
      armed_q <= RST_ZERO;
    end else if (st_rd) begin
      armed_q <= status_q;
      // Noise and parity arm on any status read, set or not
      armed_q[BIT_NOISE] <= 1'b1;
      armed_q[BIT_PARITY] <= 1'b1;
    end else begin
      // A data access consumes the arming of the flags it serves
      if (dat_rd) begin
        armed_q[BIT_PARITY] <= 1'b0;
        armed_q[BIT_FRAME] <= 1'b0;
        armed_q[BIT_NOISE] <= 1'b0;
        armed_q[BIT_OVERRUN] <= 1'b0;
        armed_q[BIT_IDLE] <= 1'b0;
        armed_q[BIT_RX_FULL] <= 1'b0;
      end
      if (dat_wr) begin
        armed_q[BIT_TX_EMPTY] <= 1'b0;
      end
      if (dat_wr || tx_rise || brk_wr) begin
        armed_q[BIT_TX_DONE] <= 1'b0;
      end
    end
  end

  // Receive data holder; overrun leaves the old character intact
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data_q <= RST_ZERO;
    end else if (rx_take) begin
      rx_data_q <= rx_char.data;
    end
  end

  // Transmit data buffer handed to the shifter
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_data_q <= RST_ZERO;
      tx_data_valid_q <= 1'b0;
    end else if (dat_wr) begin
      tx_data_q <= reg_wdata;
      tx_data_valid_q <= 1'b1;
    end else if (tx_state.load) begin
      tx_data_valid_q <= 1'b0;
    end
  end

  // Control and configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= RST_ZERO;
      cfg_q <= RST_ZERO;
    end else begin
      if (ctl_wr) begin
        ctrl_q <= reg_wdata;
      end
      if (hit(reg_wr, reg_addr, OFS_CONFIG)) begin
        cfg_q <= reg_wdata;
      end
    end
  end

  // Idle counter: counts high bit times, restarts on a low sample
  // Limitation: counts whole ticks only, so the start edge is quantised
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_q <= '0;
      idle_run_q <= 1'b0;
      idle_allow_q <= 1'b0;
    end else begin
      if (rx_take) begin
        idle_allow_q <= 1'b1;
      end else if (idle_set) begin
        idle_allow_q <= 1'b0;
      end
      if (!cfg_q[BIT_IDLE_SEL] && rx_line.start_done) begin
        idle_run_q <= 1'b1;
        idle_cnt_q <= '0;
      end else if (cfg_q[BIT_IDLE_SEL] && rx_line.stop_done) begin
        idle_run_q <= 1'b1;
        idle_cnt_q <= '0;
      end else if (cfg_q[BIT_IDLE_SEL] && rx_line.start_done) begin
        idle_run_q <= 1'b0;
        idle_cnt_q <= '0;
      end else if (idle_run_q && rx_line.bit_tick) begin
        if (!rx_line.line_high) begin
          idle_cnt_q <= '0;
        end else if (idle_cnt_q != char_bits) begin
          idle_cnt_q <= idle_cnt_q + 4'h1;
        end
      end
    end
  end

  // Sets once when a full character time of high is reached
  assign idle_set = idle_run_q && rx_line.bit_tick && rx_line.line_high &&
                    (idle_cnt_q == char_bits - 4'h1) && idle_allow_q;

  // Interrupt status: rising flags latch, write one clears, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      status_prev_q <= RST_STATUS;
      irq_stat_q <= RST_ZERO;
      irq_mask_q <= RST_ZERO;
    end else begin
      status_prev_q <= status_q;
      if (hit(reg_wr, reg_addr, OFS_IRQ_MASK)) begin
        irq_mask_q <= reg_wdata;
      end
      if (hit(reg_wr, reg_addr, OFS_IRQ_STATUS)) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata) | (status_q & ~status_prev_q);
      end else begin
        irq_stat_q <= irq_stat_q | (status_q & ~status_prev_q);
      end
    end
  end

  // Registered read data, valid the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= RST_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_STATUS_ONE: rdata_q <= status_q;
        OFS_DATA_PORT: rdata_q <= rx_data_q;
        OFS_CONTROL_TWO: rdata_q <= ctrl_q;
        OFS_CONFIG: rdata_q <= cfg_q;
        OFS_IRQ_STATUS: rdata_q <= irq_stat_q;
        OFS_IRQ_MASK: rdata_q <= irq_mask_q;
        default: rdata_q <= RD_UNMAPPED;
      endcase
    end else begin
      rdata_q <= RST_ZERO;
    end
  end

  assign reg_rdata = rdata_q;
  assign tx_data = tx_data_q;
  assign tx_data_valid = tx_data_valid_q;
  assign tx_on = ctrl_q[BIT_TX_ON];
  assign queue_break = ctrl_q[BIT_QUEUE_BREAK];
  assign parity_on = cfg_q[BIT_PARITY];
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule : usf_status_flags

/* File: sim/usf_far_end.sv */
// Far-end model: receive frames on command, transmit shifter timing.
// Assumes one bus clock shared with the block; the bench pulses send.
module usf_far_end
  import usf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic send,
  input wire usf_rx_char_t send_char,
  input wire logic tx_data_valid,
  input wire logic tx_on,
  input wire logic queue_break,
  output usf_rx_char_t rx_char,
  output usf_tx_state_t tx_state,
  output usf_rx_line_t rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] frm_q;
  logic [3:0] busy_q;
  logic on_q;
  logic tick_q;
  logic kick;
  // Load, enable rise or a held break restart the shifter's busy time
  assign kick = tx_state.load | (tx_on & ~on_q) | queue_break;
  // Twenty-cycle frame, ticks every other cycle; a break holds the shifter busy
  always_ff @(posedge clk) begin
    tick_q <= ~tick_q & ~rst;
    on_q <= tx_on;
    frm_q <= rst ? 5'h00 : send ? 5'h14 : frm_q - {4'h0, |frm_q};
    busy_q <= rst ? 4'h0 : kick ? 4'h8 : busy_q - {3'h0, |busy_q};
  end
  // Busy at once on load, enable rise or break, so done cannot slip in
  assign tx_state.load = tx_data_valid & tx_on & ~|busy_q;
  assign tx_state.busy = kick | (|busy_q);
  assign rx_char = (frm_q == 5'h01) ? send_char : '0;
  assign rx_line = '{tick_q, frm_q < 5'h13, frm_q == 5'h12, frm_q == 5'h01};
endmodule : usf_far_end

/* File: sim/usf_status_flags_chk.sv */
// Checker on the status-flag block ports: read timing, buffer, flags.
// Assumes it is bound to usf_status_flags; one clock, sync reset.
module usf_status_flags_chk
  import usf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire usf_rx_char_t rx_char,
  input wire usf_tx_state_t tx_state,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_data_valid,
  input wire logic tx_on,
  input wire logic queue_break
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside a read cycle");
  unmapped_zero_a: assert property (reg_rd && reg_addr > OFS_IRQ_MASK |=> reg_rdata == RD_UNMAPPED)
    else $error("unmapped read not zero");
  buf_fill_a: assert property (reg_wr && reg_addr == OFS_DATA_PORT |=> tx_data_valid && tx_data == $past(reg_wdata))
    else $error("data write did not fill buffer");
  buf_drain_a: assert property (tx_state.load && !reg_wr |=> !tx_data_valid)
    else $error("buffer still full after load");
  buf_hold_a: assert property (tx_data_valid && !tx_state.load && !reg_wr |=> tx_data_valid && $stable(tx_data))
    else $error("buffer changed without cause");
  ctl_write_a: assert property (reg_wr && reg_addr == OFS_CONTROL_TWO |=> tx_on == $past(reg_wdata[BIT_TX_ON]) && queue_break == $past(reg_wdata[BIT_QUEUE_BREAK]))
    else $error("control bits not written");
  rx_full_seen_a: assert property (first_match(rx_char.valid ##[1:60] (reg_rd && reg_addr == OFS_STATUS_ONE)) |=> reg_rdata[BIT_RX_FULL])
    else $error("receive full not seen after character");
  tx_empty_seen_a: assert property (first_match(tx_state.load ##[1:60] (reg_rd && reg_addr == OFS_STATUS_ONE)) |=> reg_rdata[BIT_TX_EMPTY])
    else $error("buffer empty not seen after load");
endmodule : usf_status_flags_chk

/* File: sim/usf_status_flags_bench.sv */
// Self-checking bench: bus tasks, far-end model, one task per scenario.
// Assumes the checker is bound to the block at the foot of this file.
module usf_status_flags_bench
  import usf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic [DATA_W-1:0] reg_rdata, tx_data;
  logic tx_data_valid, tx_on, queue_break, parity_on, irq;
  usf_rx_char_t rx_char, send_char = '0;
  usf_tx_state_t tx_state;
  usf_rx_line_t rx_line;
  int mismatches = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  usf_status_flags i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_char, .tx_state, .rx_line, .tx_data, .tx_data_valid, .tx_on, .queue_break,
    .parity_on, .irq);
  usf_far_end i_far (.clk, .rst, .send, .send_char, .tx_data_valid, .tx_on, .queue_break,
    .rx_char, .tx_state, .rx_line);
  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Strobes last one cycle; read data are taken in the cycle after
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] m, input logic [7:0] e, input logic [3:0] a = OFS_STATUS_ONE);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask : rd
  // One received frame, then wait it out
  task automatic rx(input logic [7:0] d, input logic [2:0] err);
    @(posedge clk);
    {send_char, send} <= {1'b1, d, err, 1'b1};
    @(posedge clk);
    send <= 1'b0;
    repeat (24) @(posedge clk);
  endtask : rx
  // Fill without and with an armed status read, then send
  task automatic t_tx;
    wr(OFS_DATA_PORT, 8'h5A);
    rd(8'hFF, RST_STATUS);
    wr(OFS_DATA_PORT, 8'hA5);
    rd(8'hFF, 8'h00);
    wr(OFS_CONTROL_TWO, 8'h08);
    rd(8'hC0, 8'h80);
    repeat (9) @(posedge clk);
    wr(OFS_STATUS_ONE, 8'h00);
    rd(8'hFF, 8'hC0);
    rd(8'hFF, RD_UNMAPPED, 4'hE);
  endtask : t_tx
  // Each of the three actions clears an armed done flag
  task automatic t_txdone;
    logic [7:0] pre [3] = '{8'h08, 8'h00, 8'h08};
    logic [3:0] ofs [3] = '{OFS_DATA_PORT, OFS_CONTROL_TWO, OFS_CONTROL_TWO};
    logic [7:0] act [3] = '{8'h33, 8'h08, 8'h09};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CONTROL_TWO, pre[i]);
      rd(8'h40, 8'h40);
      wr(ofs[i], act[i]);
      rd(8'h40, 8'h00);
      wr(OFS_CONTROL_TWO, 8'h08);
      repeat (12) @(posedge clk);
      rd(8'hC0, 8'hC0);
    end
  endtask : t_txdone
  // Overrun drops the newer frame; interrupt raised, masked, cleared
  task automatic t_rx;
    wr(OFS_IRQ_MASK, 8'h20);
    rx(8'h3C, 3'b000);
    #1 chk({7'h00, irq}, 8'h01);
    wr(OFS_IRQ_MASK, 8'h00);
    #1 chk({7'h00, irq}, 8'h00);
    wr(OFS_IRQ_MASK, 8'h20);
    rx(8'hC3, 3'b010);
    rd(8'h2B, 8'h28);
    rd(8'hFF, 8'h3C, OFS_DATA_PORT);
    rd(8'h2F, 8'h00);
    wr(OFS_IRQ_STATUS, 8'h20);
    #1 chk({7'h00, irq}, 8'h00);
  endtask : t_rx
  // Each error flag rises with receive full and clears by read sequence
  task automatic t_err;
    wr(OFS_CONFIG, 8'h01);
    for (int i = 0; i < 3; i++) begin
      rx(8'h0F, 3'b001 << i);
      rd(8'h27, 8'h20 | (8'h01 << i));
      rd(8'hFF, 8'h0F, OFS_DATA_PORT);
      rd(8'h27, 8'h00);
    end
  endtask : t_err
  // Idle count start for both selections; a long idle sets once
  task automatic t_idle;
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CONFIG, s ? 8'h04 : 8'h00);
      rx(8'hFF, 3'b000);
      rd(8'h10, s ? 8'h00 : 8'h10);
      repeat (20) @(posedge clk);
      rd(8'h10, 8'h10);
      rd(8'hFF, 8'hFF, OFS_DATA_PORT);
      repeat (40) @(posedge clk);
      rd(8'h30, 8'h00);
    end
  endtask : t_idle
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_tx;
    t_txdone;
    t_rx;
    t_err;
    t_idle;
    report_and_stop;
  end
endmodule : usf_status_flags_bench
bind usf_status_flags usf_status_flags_chk i_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .rx_char, .tx_state, .tx_data, .tx_data_valid, .tx_on, .queue_break);
